/* acs_seq.sv */
`timescale 1ns/100ps
// What this block does
// - Single-channel with continuous select clear converts one channel four times into slots 1..4.
// - With continuous select clear, activity stops after the fourth conversion until a new command.
// - Single-channel with continuous select set keeps converting, wrapping into slot 1 again.
// - Group mode with continuous select clear converts each of four channels once into slots 1..4.
// - Group mode with continuous select set keeps cycling the group, overwriting slots in order.
// - Each conversion takes 32 clock cycles from start to stored result.
// - The sampling phase at the start of each conversion lasts 12 clock cycles.
// - Results are 8 bits, low reference reads 00 and high reference reads ff.
module acs_seq
  import acs_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  input  wire logic             i_cmd_write,
  input  wire logic             i_scan,
  input  wire logic             i_group_conversion_select,
  input  wire logic [2:0]       i_channel,
  input  wire logic             i_sar_bit,
  output logic                  o_sample,
  output logic                  o_busy,
  output logic [2:0]            o_mux_channel,
  output logic                  o_sar_valid,
  output logic [RES_W-1:0]      o_sar_trial,
  output logic [RES_W-1:0]      o_result_slot_1,
  output logic [RES_W-1:0]      o_result_slot_2,
  output logic [RES_W-1:0]      o_result_slot_3,
  output logic [RES_W-1:0]      o_result_slot_4
);

  acs_state_t       state;
  acs_state_t       next_state;
  logic [4:0]       cnt;
  logic [4:0]       next_cnt;
  logic [1:0]       slot;
  logic [1:0]       next_slot;
  logic             scan;
  logic             next_scan;
  logic             grp;
  logic             next_grp;
  logic [2:0]       chan;
  logic [2:0]       next_chan;
  logic [RES_W-1:0] sar;
  logic [RES_W-1:0] next_sar;
  logic [RES_W-1:0] slots      [NUM_SLOTS];
  logic [RES_W-1:0] next_slots [NUM_SLOTS];

  // Trial bit position for an approximation cycle
  function automatic logic [2:0] sar_pos(input logic [4:0] c);
    logic [4:0] d;
    d = c - SAMPLE_LAST - 5'h01;
    return 3'h7 - d[2:0];
  endfunction

  // Channel on the mux: group base plus slot, or the single channel
  function automatic logic [2:0] mux_of(input logic g, input logic [2:0] ch,
                                         input logic [1:0] s);
    return g ? {ch[2], s} : ch;
  endfunction

  // SAR bits: approximation spans counts 12..19, the rest settles the result
  function automatic logic sar_active(input logic [4:0] c);
    return (c > SAMPLE_LAST) && (c <= SAMPLE_LAST + 5'h08);
  endfunction

  // Next-state logic
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_slot  = slot;
    next_scan  = scan;
    next_grp   = grp;
    next_chan  = chan;
    next_sar   = sar;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      next_slots[i] = slots[i];
    end
    if (i_cmd_write) begin
      next_state = ACS_SAMPLE;
      next_cnt   = CNT_RST;
      next_slot  = SLOT_RST;
      next_scan  = i_scan;
      next_grp   = i_group_conversion_select;
      next_chan  = i_channel;
      next_sar   = RES_ZERO;
    end else begin
      case (state)
        ACS_IDLE: begin
          next_cnt = CNT_RST;
        end
        ACS_SAMPLE: begin
          next_cnt = cnt + 5'h01;
          if (cnt == SAMPLE_LAST) begin
            next_state = ACS_APPROX;
            next_sar   = 8'h80;
          end
        end
        ACS_APPROX: begin
          next_cnt = cnt + 5'h01;
          if (sar_active(cnt)) begin
            next_sar[sar_pos(cnt)] = i_sar_bit;
            if (sar_pos(cnt) != 3'h0) begin
              next_sar[sar_pos(cnt) - 3'h1] = 1'b1;
            end
          end
          if (cnt == CNT_LAST) begin
            next_slots[slot] = sar;
            next_slot        = slot + 2'h1;
            next_cnt         = CNT_RST;
            next_sar         = RES_ZERO;
            if (slot == 2'h3 && !scan) begin
              next_state = ACS_IDLE;
            end else begin
              next_state = ACS_SAMPLE;
            end
          end
        end
        default: begin
          next_state = ACS_IDLE;
          next_cnt   = CNT_RST;
        end
      endcase
    end
  end

  // State registers, frozen while clock enable is low
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ACS_IDLE;
      cnt   <= CNT_RST;
      slot  <= SLOT_RST;
      scan  <= 1'b0;
      grp   <= 1'b0;
      chan  <= CHAN_RST;
      sar   <= RES_ZERO;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slots[i] <= RES_ZERO;
      end
    end else if (i_ce) begin
      state <= next_state;
      cnt   <= next_cnt;
      slot  <= next_slot;
      scan  <= next_scan;
      grp   <= next_grp;
      chan  <= next_chan;
      sar   <= next_sar;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slots[i] <= next_slots[i];
      end
    end
  end

  // Outputs to the analog core and the processor
  assign o_sample        = (state == ACS_SAMPLE);
  assign o_busy          = (state != ACS_IDLE);
  assign o_mux_channel   = mux_of(grp, chan, slot);
  assign o_sar_valid     = (state == ACS_APPROX) && sar_active(cnt);
  assign o_sar_trial     = sar;
  assign o_result_slot_1 = slots[0];
  assign o_result_slot_2 = slots[1];
  assign o_result_slot_3 = slots[2];
  assign o_result_slot_4 = slots[3];

  a_sample_len: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(o_sample) && i_ce && !i_cmd_write |-> o_sample [*8])
    else $error("sample phase ended early");

  a_sample_span: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_busy |-> (o_sample == (cnt <= SAMPLE_LAST)))
    else $error("sample phase outside its count window");

  // count steps by one through all 32 cycles of a conversion
  a_conv_len: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && !i_cmd_write && o_busy && (cnt != CNT_LAST) |=>
    o_busy && (cnt == $past(cnt) + 5'h01))
    else $error("conversion count skipped or stopped");

  // halted stays halted without a command
  a_halt_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state == ACS_IDLE) && !i_cmd_write |=> (state == ACS_IDLE))
    else $error("left idle without a command");

  a_halt_last: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && !i_cmd_write && (state == ACS_APPROX) && (cnt == CNT_LAST) && (slot == 2'h3)
    && !scan |=> (state == ACS_IDLE))
    else $error("one-shot did not halt after slot 4");

  a_scan_wrap: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && !i_cmd_write && (state == ACS_APPROX) && (cnt == CNT_LAST) && (slot == 2'h3)
    && scan |=> (state == ACS_SAMPLE) && (slot == 2'h0))
    else $error("scan did not wrap to slot 1");

  // stored result lands in slot 2 when slot 2 is current
  a_slot_store: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && !i_cmd_write && (state == ACS_APPROX) && (cnt == CNT_LAST) && (slot == 2'h1)
    |=> o_result_slot_2 == $past(sar))
    else $error("result not stored in slot 2");

  a_group_mux: assert property (@(posedge i_clk) disable iff (!i_resetn)
    grp && o_busy |-> o_mux_channel[1:0] == slot)
    else $error("group mux does not follow slot");

  // mux channel held for a whole conversion
  a_mux_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && !i_cmd_write && o_busy && (cnt != CNT_LAST) |=> $stable(o_mux_channel))
    else $error("mux channel changed mid conversion");

  a_cmd_restart: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_cmd_write && i_ce |=> (slot == 2'h0) && o_sample && (cnt == CNT_RST))
    else $error("command did not restart at slot 1");

  // eight trial cycles per conversion
  // A command inside the window restarts the conversion, so it ends the check
  a_sar_window: assert property (@(posedge i_clk) disable iff (!i_resetn || i_cmd_write)
    o_sar_valid && (cnt == SAMPLE_LAST + 5'h01) && i_ce && !i_cmd_write
    |=> o_sar_valid [*7])
    else $error("trial window shorter than eight cycles");

endmodule

/* acs_pkg.sv */
package acs_pkg;
  // Conversion timing in clock cycles
  localparam int unsigned CONV_CYCLES   = 32;
  localparam int unsigned SAMPLE_CYCLES = 12;
  localparam logic [4:0]  CNT_LAST      = 5'h1f;
  localparam logic [4:0]  SAMPLE_LAST   = 5'h0b;
  // Result width and extremes
  localparam int unsigned RES_W         = 8;
  localparam logic [7:0]  RES_ZERO      = 8'h00;
  localparam logic [7:0]  RES_FULL      = 8'hff;
  localparam int unsigned NUM_SLOTS     = 4;
  // Reset values
  localparam logic [1:0]  SLOT_RST      = 2'h0;
  localparam logic [4:0]  CNT_RST       = 5'h00;
  localparam logic [2:0]  CHAN_RST      = 3'h0;

  // Sequencer states, Gray coded along idle -> sample -> approx
  typedef enum logic [1:0] {
    ACS_IDLE   = 2'b00,
    ACS_SAMPLE = 2'b01,
    ACS_APPROX = 2'b11
  } acs_state_t;
endpackage

/* acs_analog_model.sv */
`timescale 1ns/100ps
// Comparator and input mux of the analog core, one fixed level per channel
module acs_analog_model (
  input  wire logic       i_clk,
  input  wire logic       i_sar_valid,
  input  wire logic [2:0] i_mux_channel,
  input  wire logic [7:0] i_sar_trial,
  input  wire logic [7:0] i_bias,
  output logic            o_sar_bit
);
  logic       toggle;
  logic [7:0] level;

  // Junk pattern while no trial runs
  initial toggle = 1'b0;
  always @(posedge i_clk) toggle <= ~toggle;

  // Channel 0 at low reference, channel 1 at high reference
  always_comb begin
    case (i_mux_channel)
      3'h0:    level = 8'h00;
      3'h1:    level = 8'hff;
      default: level = 8'h11 * i_mux_channel;
    endcase
    o_sar_bit = i_sar_valid ? (i_sar_trial <= (level ^ i_bias)) : toggle;
  end
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import acs_pkg::*;
  logic i_clk, i_resetn, i_cmd_write, i_scan, i_grp, sar_bit, o_sample, o_busy, o_sar_valid;
  logic       i_ce;
  logic [2:0] i_channel, o_mux_channel;
  logic [7:0] i_bias, o_sar_trial, s1, s2, s3, s4;
  int   n_fail, num_checks;

  acs_seq DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_cmd_write(i_cmd_write),
    .i_scan(i_scan), .i_group_conversion_select(i_grp), .i_channel(i_channel),
    .i_sar_bit(sar_bit), .o_sample(o_sample), .o_busy(o_busy), .o_mux_channel(o_mux_channel),
    .o_sar_valid(o_sar_valid), .o_sar_trial(o_sar_trial), .o_result_slot_1(s1),
    .o_result_slot_2(s2), .o_result_slot_3(s3), .o_result_slot_4(s4));
  acs_analog_model PARTNER (.i_clk(i_clk), .i_sar_valid(o_sar_valid),
    .i_mux_channel(o_mux_channel), .i_sar_trial(o_sar_trial), .i_bias(i_bias),
    .o_sar_bit(sar_bit));

  task stop_test;
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Expected reading of each channel
  function logic [7:0] lvl(input logic [2:0] ch);
    lvl = (ch == 3'h0) ? 8'h00 : (ch == 3'h1) ? 8'hff : 8'h11 * ch;
  endfunction

  function logic [2:0] chan(input logic g, input logic [2:0] c, input logic [1:0] k);
    chan = g ? {c[2], k} : c;
  endfunction

  task cmd(input logic s, input logic g, input logic [2:0] c);
    @(negedge i_clk);
    {i_cmd_write, i_scan, i_grp, i_channel} = {1'b1, s, g, c};
    @(negedge i_clk);
    i_cmd_write = 1'b0;
  endtask

  // One-shot sequence: timing, halt and all four slots
  task one_shot(input logic g, input logic [2:0] c);
    int nb, ns, nv;
    nb = 0;
    ns = 0;
    nv = 0;
    cmd(1'b0, g, c);
    repeat (199) begin
      nb += int'(o_busy === 1'b1);
      ns += int'(o_sample === 1'b1);
      nv += int'(o_sar_valid === 1'b1);
      @(negedge i_clk);
    end
    chk(8'h80, nb[7:0]);
    chk(8'h30, ns[7:0]);
    chk(8'h20, nv[7:0]);
    chk(8'h00, {7'h0, o_busy});
    chk(lvl(chan(g, c, 2'd0)), s1);
    chk(lvl(chan(g, c, 2'd1)), s2);
    chk(lvl(chan(g, c, 2'd2)), s3);
    chk(lvl(chan(g, c, 2'd3)), s4);
  endtask

  // Continuous run: fifth result lands in slot 1, slot 2 untouched yet
  task scan_run(input logic g, input logic [2:0] c);
    i_bias = 8'h00;
    cmd(1'b1, g, c);
    repeat (132) @(negedge i_clk);
    i_bias = 8'h5a;
    repeat (33) @(negedge i_clk);
    chk(lvl(chan(g, c, 2'd0)) ^ 8'h5a, s1);
    chk(lvl(chan(g, c, 2'd1)), s2);
    chk(8'h01, {7'h0, o_busy});
    chk({5'h0, chan(g, c, 2'h1)}, {5'h0, o_mux_channel});
  endtask

  // New command mid-run restarts at slot 1
  task abort_run;
    i_bias = 8'h00;
    cmd(1'b0, 1'b0, 3'h3);
    repeat (33) @(negedge i_clk);
    chk(lvl(3'h3), s1);
    // Slot 2 still holds the group scan's second result
    chk(lvl(3'h5), s2);
  endtask

  // Clock enable low freezes a conversion after its trials
  task freeze_run;
    int nb;
    nb = 0;
    i_bias = 8'h00;
    cmd(1'b0, 1'b0, 3'h2);
    repeat (20) @(negedge i_clk);
    i_ce = 1'b0;
    repeat (40) begin
      nb += int'(o_busy === 1'b1);
      @(negedge i_clk);
    end
    chk(8'h28, nb[7:0]);
    chk(lvl(3'h2), o_sar_trial);
    chk(lvl(3'h3), s1);
    i_ce = 1'b1;
    repeat (107) @(negedge i_clk);
    chk(8'h01, {7'h0, o_busy});
    @(negedge i_clk);
    chk(8'h00, {7'h0, o_busy});
    chk(lvl(3'h2), s1);
    chk(lvl(3'h2), s2);
    chk(lvl(3'h2), s3);
    chk(lvl(3'h2), s4);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    {i_resetn, i_cmd_write, i_scan, i_grp, i_channel, i_bias} = '0;
    i_ce = 1'b1;
    n_fail = 0;
    num_checks = 0;
    repeat (16) @(negedge i_clk);
    i_resetn = 1'b1;
    one_shot(1'b0, 3'h0);
    one_shot(1'b0, 3'h1);
    one_shot(1'b0, 3'h5);
    one_shot(1'b1, 3'h0);
    one_shot(1'b1, 3'h4);
    scan_run(1'b0, 3'h6);
    scan_run(1'b1, 3'h4);
    abort_run;
    freeze_run;
    stop_test;
  end
endmodule
